// ===== pkg/b2s_pkg.sv
// shared constants for both ends of the two-word burst memory port
// assumes a single 100 MHz clock at each end; link pins cross by synchronisers
//
// What this block does
// - write words taken at positive, then negative edge
// - two arrays, each address selects word pair
// - load strobe low starts one transaction
// - each transaction moves exactly two words
// - direction high reads, low writes
// - address sampled only at positive edge accesses
// - one address bus shared by reads and writes
// - address width 21, 20 or 19 bits
// - address ignored when no port selected
// - nibble masks qualify bits 3:0 and 7:4
// - masked nibble left unchanged in memory
// - byte masks cover nine-bit lanes per edge
// - masked byte left unchanged in memory
// - read words on output or input clock edges
// - read outputs released when no read selected
// - accesses start at positive input clock edge
// - free-running echo strobes follow the read clock
package b2s_pkg;
  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int ADDR_W = (DATA_W <= 9) ? 21 : (DATA_W == 18) ? 20 : 19;
  localparam int LANE_W = (DATA_W == 8) ? 4 : 9;
  localparam int MASK_W = DATA_W / LANE_W;
  localparam int DEPTH  = 1 << ADDR_W;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 160;
  // must be a power of two: the link clock is the top phase bit
  localparam int LINK_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PH_W        = $clog2(LINK_CYCLES);
  localparam logic [PH_W-1:0] PH_FIRST  = PH_W'(LINK_CYCLES * 3 / 4);
  localparam logic [PH_W-1:0] PH_SECOND = PH_W'(LINK_CYCLES / 4);

  // ---------------------------------------------------------------
  // read output sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_W0   = 3'b010,
    RD_W1   = 3'b100
  } b2s_rd_state_t;
endpackage

// ===== pkg/b2s_if.sv
// pin bundle between the memory and its controller
// assumes both ends sample every pin with their own clock
`timescale 1ns/1ns
interface b2s_if;
  import b2s_pkg::*;
  logic              k;
  logic              k_n;
  logic              c;
  logic              c_n;
  logic              cycle_load_n;
  logic              rw;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [MASK_W-1:0] byte_mask_n;
  logic [DATA_W-1:0] q;
  logic              q_oe;
  logic              echo_strobe;
  logic              echo_strobe_n;

  modport dev (
    input  k, k_n, c, c_n, cycle_load_n, rw, addr, wdata, byte_mask_n,
    output q, q_oe, echo_strobe, echo_strobe_n
  );
  modport ctl (
    output k, k_n, c, c_n, cycle_load_n, rw, addr, wdata, byte_mask_n,
    input  q, q_oe, echo_strobe, echo_strobe_n
  );
endinterface

// ===== design/b2s_sram_dev.sv
// memory end: two word arrays behind the burst pin interface
// assumes link pins are asynchronous to clock_i and change well clear of edges
`timescale 1ns/1ns
module b2s_sram_dev
  import b2s_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // strap: read data timed by the input clock pair
  input  wire logic single_clk_i,
  // link
  b2s_if.dev        link
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int IN_W = 7 + ADDR_W + DATA_W + MASK_W;

  logic [IN_W-1:0] pin_raw;
  logic [IN_W-1:0] pin_s1;
  logic [IN_W-1:0] pin_s2;

  assign pin_raw = {link.k, link.k_n, link.c, link.c_n, link.cycle_load_n,
                    link.rw, link.addr, link.wdata, link.byte_mask_n,
                    single_clk_i};

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  logic              k_s;
  logic              kn_s;
  logic              c_s;
  logic              cn_s;
  logic              load_n_s;
  logic              rw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;
  logic [MASK_W-1:0] mask_n_s;
  logic              single_s;

  assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_s, addr_s, wdata_s, mask_n_s,
          single_s} = pin_s2;

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic k_d;
  logic kn_d;
  logic c_d;
  logic cn_d;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      k_d  <= 1'b0;
      kn_d <= 1'b0;
      c_d  <= 1'b0;
      cn_d <= 1'b0;
    end
    else
    begin
      k_d  <= k_s;
      kn_d <= kn_s;
      c_d  <= c_s;
      cn_d <= cn_s;
    end
  end

  wire k_rise  = k_s & ~k_d;
  wire kn_rise = kn_s & ~kn_d;
  wire oc_rise = single_s ? k_rise : (c_s & ~c_d);
  wire oc_fall = single_s ? kn_rise : (cn_s & ~cn_d);
  wire oc_lvl  = single_s ? k_s : c_s;
  wire ocn_lvl = single_s ? kn_s : cn_s;

  // ---------------------------------------------------------------
  // transaction decode
  // ---------------------------------------------------------------
  // load high decodes to nothing: no array touched, address unused
  wire load_go  = k_rise & ~load_n_s;
  wire rd_start = load_go & rw_s;
  wire wr_start = load_go & ~rw_s;

  // ---------------------------------------------------------------
  // arrays and masked merge
  // ---------------------------------------------------------------
  // one array per burst word, indexed by the same address
  logic [DATA_W-1:0] mem0 [DEPTH];
  logic [DATA_W-1:0] mem1 [DEPTH];

  logic [ADDR_W-1:0] wr_addr;
  logic              wr_pend;
  logic [DATA_W-1:0] old0;
  logic [DATA_W-1:0] old1;
  logic [DATA_W-1:0] next_word0;
  logic [DATA_W-1:0] next_word1;

  assign old0 = mem0[addr_s];
  assign old1 = mem1[wr_addr];

  // nibble lanes on the 8-bit build, 9-bit lanes otherwise
  for (genvar l = 0; l < MASK_W; l++)
  begin : g_lane
    assign next_word0[l*LANE_W +: LANE_W] = mask_n_s[l] ?
      old0[l*LANE_W +: LANE_W] : wdata_s[l*LANE_W +: LANE_W];
    assign next_word1[l*LANE_W +: LANE_W] = mask_n_s[l] ?
      old1[l*LANE_W +: LANE_W] : wdata_s[l*LANE_W +: LANE_W];
  end

  // first word at the positive edge, second at the following negative edge
  always_ff @(posedge clock_i)
  begin
    if (wr_start)
      mem0[addr_s] <= next_word0;
    if (kn_rise && wr_pend)
      mem1[wr_addr] <= next_word1;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else if (wr_start)
    begin
      wr_pend <= 1'b1;
      wr_addr <= addr_s;
    end
    else if (kn_rise)
      wr_pend <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read fetch
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rd0;
  logic [DATA_W-1:0] rd1;
  logic              rd_pend;
  b2s_rd_state_t     rd_state;
  b2s_rd_state_t     next_rd_state;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rd0 <= '0;
      rd1 <= '0;
    end
    else if (rd_start)
    begin
      rd0 <= mem0[addr_s];
      rd1 <= mem1[addr_s];
    end
  end

  // a fetch landing on the launch edge waits for the next one
  wire launch = oc_rise & rd_pend;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      rd_pend <= 1'b0;
    else if (rd_start)
      rd_pend <= 1'b1;
    else if (launch)
      rd_pend <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read output sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rd_state = rd_state;
    unique case (rd_state)
      RD_IDLE:
        if (launch)
          next_rd_state = RD_W0;
      RD_W0:
        if (oc_fall)
          next_rd_state = RD_W1;
      RD_W1:
        if (launch)
          next_rd_state = RD_W0;
        else if (oc_rise)
          next_rd_state = RD_IDLE;
      default:
        next_rd_state = RD_IDLE;
    endcase
  end

  logic [DATA_W-1:0] q;
  logic              q_oe;
  logic              echo;
  logic              echo_n;
  // a back-to-back fetch reloads rd1 on the launch edge, so word1 is parked here
  logic [DATA_W-1:0] q_word1;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rd_state <= RD_IDLE;
      q        <= '0;
      q_word1  <= '0;
      q_oe     <= 1'b0;
      echo     <= 1'b0;
      echo_n   <= 1'b0;
    end
    else
    begin
      rd_state <= next_rd_state;
      echo     <= oc_lvl;
      echo_n   <= ocn_lvl;
      if (launch)
      begin
        q       <= rd0;
        q_word1 <= rd1;
        q_oe    <= 1'b1;
      end
      else if (rd_state == RD_W0 && oc_fall)
        q <= q_word1;
      else if (rd_state == RD_W1 && oc_rise)
        q_oe <= 1'b0;
    end
  end

  assign link.q             = q;
  assign link.q_oe          = q_oe;
  assign link.echo_strobe   = echo;
  assign link.echo_strobe_n = echo_n;
endmodule

// ===== design/b2s_sram_ctl.sv
// controller end: makes the link clock and runs one burst per period
// assumes the memory end drives echo strobes aligned to its read data
`timescale 1ns/1ns
module b2s_sram_ctl
  import b2s_pkg::*;
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  // request
  input  wire logic              req_valid_i,
  input  wire logic              req_read_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata0_i,
  input  wire logic [DATA_W-1:0] req_wdata1_i,
  input  wire logic [MASK_W-1:0] req_mask0_n_i,
  input  wire logic [MASK_W-1:0] req_mask1_n_i,
  output logic                   req_ready_o,
  // read answer
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_data0_o,
  output logic [DATA_W-1:0]      rsp_data1_o,
  // link
  b2s_if.ctl                     link
);
  // ---------------------------------------------------------------
  // link clock divider
  // ---------------------------------------------------------------
  logic [PH_W-1:0] phase;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      phase <= '0;
    else
      phase <= phase + 1'b1;
  end

  // high for the first half period; the output pair copies the input pair
  assign link.k   = ~phase[PH_W-1];
  assign link.k_n = phase[PH_W-1];
  assign link.c   = ~phase[PH_W-1];
  assign link.c_n = phase[PH_W-1];

  // ---------------------------------------------------------------
  // request holding and pin launch
  // ---------------------------------------------------------------
  logic              pend;
  logic              p_read;
  logic [ADDR_W-1:0] p_addr;
  logic [DATA_W-1:0] p_d0;
  logic [DATA_W-1:0] p_d1;
  logic [MASK_W-1:0] p_m0;
  logic [MASK_W-1:0] p_m1;
  logic [DATA_W-1:0] word1;
  logic [MASK_W-1:0] mask1;
  logic              load_n;
  logic              rw;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [MASK_W-1:0] mask_n;

  assign req_ready_o = ~pend;
  wire take     = req_valid_i & ~pend;
  // pins change three cycles, just under a quarter period, before each link edge for margin
  wire at_first = (phase == PH_FIRST);
  wire at_second = (phase == PH_SECOND);

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pend <= 1'b0;
    else if (take)
      pend <= 1'b1;
    else if (at_first)
      pend <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (take)
    begin
      p_read <= req_read_i;
      p_addr <= req_addr_i;
      p_d0   <= req_wdata0_i;
      p_d1   <= req_wdata1_i;
      p_m0   <= req_mask0_n_i;
      p_m1   <= req_mask1_n_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      load_n <= 1'b1;
      rw     <= 1'b1;
      addr   <= '0;
      wdata  <= '0;
      mask_n <= '1;
      word1  <= '0;
      mask1  <= '1;
    end
    else if (at_first)
    begin
      load_n <= ~pend;
      rw     <= p_read;
      addr   <= p_addr;
      wdata  <= p_d0;
      mask_n <= p_m0;
      word1  <= p_d1;
      mask1  <= p_m1;
    end
    else if (at_second)
    begin
      wdata  <= word1;
      mask_n <= mask1;
    end
  end

  assign link.cycle_load_n = load_n;
  assign link.rw           = rw;
  assign link.addr         = addr;
  assign link.wdata        = wdata;
  assign link.byte_mask_n  = mask_n;

  // ---------------------------------------------------------------
  // read capture on echo strobes
  // ---------------------------------------------------------------
  localparam int RX_W = 3 + DATA_W;

  logic [RX_W-1:0] rx_s1;
  logic [RX_W-1:0] rx_s2;
  logic            e_d;
  logic            en_d;
  logic            got0;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rx_s1 <= '0;
      rx_s2 <= '0;
      e_d   <= 1'b0;
      en_d  <= 1'b0;
    end
    else
    begin
      rx_s1 <= {link.echo_strobe, link.echo_strobe_n, link.q_oe, link.q};
      rx_s2 <= rx_s1;
      e_d   <= rx_s2[RX_W-1];
      en_d  <= rx_s2[RX_W-2];
    end
  end

  wire              e_rise  = rx_s2[RX_W-1] & ~e_d;
  wire              en_rise = rx_s2[RX_W-2] & ~en_d;
  wire              oe_s    = rx_s2[DATA_W];
  wire [DATA_W-1:0] q_s     = rx_s2[DATA_W-1:0];

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      got0        <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data0_o <= '0;
      rsp_data1_o <= '0;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      if (e_rise && oe_s)
      begin
        rsp_data0_o <= q_s;
        got0        <= 1'b1;
      end
      else if (en_rise && oe_s && got0)
      begin
        rsp_data1_o <= q_s;
        rsp_valid_o <= 1'b1;
        got0        <= 1'b0;
      end
    end
  end
endmodule

// ===== testbench/b2s_link_assertions.sv
// timing checks on the pins between memory end and controller end
// assumes its inputs are the shared link signals, sampled by clock_i
`timescale 1ns/1ns
module b2s_link_assertions
  import b2s_pkg::*;
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  // link
  input  wire logic              k,
  input  wire logic              k_n,
  input  wire logic              c,
  input  wire logic              c_n,
  input  wire logic              cycle_load_n,
  input  wire logic              rw,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [MASK_W-1:0] byte_mask_n,
  input  wire logic [DATA_W-1:0] q,
  input  wire logic              q_oe,
  input  wire logic              echo_strobe,
  input  wire logic              echo_strobe_n
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_kpair_complement: assert property (k_n == !k)
    else $error("input clock pair not complementary");
  a_k_period: assert property ($rose(k) |-> ##16 $rose(k))
    else $error("input clock period not sixteen cycles");
  a_cpair_follow: assert property (c == k && c_n == k_n)
    else $error("output clock pair not following input pair");
  a_load_held: assert property ($rose(k) |-> $stable(cycle_load_n) && $stable(rw) && $stable(addr))
    else $error("load, direction or address moved at k rise");
  a_word1_held: assert property ($rose(k_n) |-> $stable(wdata) && $stable(byte_mask_n))
    else $error("second write word moved at k_n rise");
  a_read_answer: assert property ($rose(k) && !cycle_load_n && rw |-> ##[17:21] q_oe)
    else $error("read load not answered one period later");
  a_idle_release: assert property ($rose(k) && cycle_load_n |-> ##22 !q_oe)
    else $error("read outputs driven without a read load");
  a_write_no_drive: assert property ($rose(k) && !cycle_load_n && !rw |-> ##22 !q_oe)
    else $error("write load drove read outputs");
  a_echo_low_phase: assert property ($fell(echo_strobe) |-> ##[6:10] $rose(echo_strobe))
    else $error("echo strobe not free running");
  a_q_steady: assert property (q_oe && $past(q_oe) && $stable(echo_strobe) && $stable(echo_strobe_n)
    |-> $stable(q))
    else $error("read word changed between echo edges");

  c_write_load: cover property ($rose(k) && !cycle_load_n && !rw);
  c_read_load: cover property ($rose(k) && !cycle_load_n && rw);
  c_read_back_to_back: cover property ($rose(echo_strobe) && q_oe && $past(q_oe));
endmodule

// ===== testbench/burst2_sram_port_tb_top.sv
// self-checking bench: controller end and memory end joined by the link
// assumes the 18-bit build, two nine-bit lanes per word
`timescale 1ns/1ns
module burst2_sram_port_tb_top
  import b2s_pkg::*;
;
  // read rows carry the expected words in w0/w1
  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
    logic [MASK_W-1:0] m0;
    logic [MASK_W-1:0] m1;
  } b2s_row_t;

  logic              clock_i;
  logic              srst_i      = 1'b1;
  logic              single_clk  = 1'b0;
  logic              req_valid   = 1'b0;
  logic              req_read    = 1'b0;
  logic [ADDR_W-1:0] req_addr    = '0;
  logic [DATA_W-1:0] req_wdata0  = '0;
  logic [DATA_W-1:0] req_wdata1  = '0;
  logic [MASK_W-1:0] req_mask0_n = '1;
  logic [MASK_W-1:0] req_mask1_n = '1;
  logic              req_ready;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data0;
  logic [DATA_W-1:0] rsp_data1;
  int                miscompares = 0;
  int                n_compared  = 0;
  int                cycles      = 0;

  b2s_row_t rows [7] = '{
    '{1'b0, 20'h00000, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0},
    '{1'b1, 20'h00000, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0},
    '{1'b0, 20'hfffff, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0},
    '{1'b0, 20'hfffff, 18'h00000, 18'h00000, 2'h2, 2'h1},
    '{1'b1, 20'hfffff, 18'h3fe00, 18'h001ff, 2'h0, 2'h0},
    '{1'b0, 20'h00000, 18'h00000, 18'h00000, 2'h3, 2'h3},
    '{1'b1, 20'h00000, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0}
  };

  b2s_if bus ();

  b2s_sram_dev b2s_sram_dev_inst (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .single_clk_i (single_clk),
    .link         (bus.dev)
  );

  b2s_sram_ctl b2s_sram_ctl_inst (
    .clock_i       (clock_i),
    .srst_i        (srst_i),
    .req_valid_i   (req_valid),
    .req_read_i    (req_read),
    .req_addr_i    (req_addr),
    .req_wdata0_i  (req_wdata0),
    .req_wdata1_i  (req_wdata1),
    .req_mask0_n_i (req_mask0_n),
    .req_mask1_n_i (req_mask1_n),
    .req_ready_o   (req_ready),
    .rsp_valid_o   (rsp_valid),
    .rsp_data0_o   (rsp_data0),
    .rsp_data1_o   (rsp_data1),
    .link          (bus.ctl)
  );

  b2s_link_assertions b2s_link_assertions_inst (
    .clock_i       (clock_i),
    .srst_i        (srst_i),
    .k             (bus.k),
    .k_n           (bus.k_n),
    .c             (bus.c),
    .c_n           (bus.c_n),
    .cycle_load_n  (bus.cycle_load_n),
    .rw            (bus.rw),
    .addr          (bus.addr),
    .wdata         (bus.wdata),
    .byte_mask_n   (bus.byte_mask_n),
    .q             (bus.q),
    .q_oe          (bus.q_oe),
    .echo_strobe   (bus.echo_strobe),
    .echo_strobe_n (bus.echo_strobe_n)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ---------------------------------------------------------------
  // hang guard: whole run needs well under a thousand cycles
  // ---------------------------------------------------------------
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      $display("BAD t=%0t timeout", $time);
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check_d(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ready is looked at mid-cycle, the request goes out on the next edge
  task automatic send(input b2s_row_t r);
    @(negedge clock_i);
    while (req_ready !== 1'b1)
      @(negedge clock_i);
    @(posedge clock_i);
    req_valid   <= 1'b1;
    req_read    <= r.rd;
    req_addr    <= r.a;
    req_wdata0  <= r.w0;
    req_wdata1  <= r.w1;
    req_mask0_n <= r.m0;
    req_mask1_n <= r.m1;
    @(posedge clock_i);
    req_valid   <= 1'b0;
  endtask

  task automatic expect_rd(input b2s_row_t r);
    int n;
    n = 0;
    @(negedge clock_i);
    while (rsp_valid !== 1'b1 && n < 200)
    begin
      @(negedge clock_i);
      n++;
    end
    check_b(rsp_valid, 1'b1);
    check_d(rsp_data0, r.w0);
    check_d(rsp_data1, r.w1);
  endtask

  task automatic test_done();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reset_pulse();
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    check_b(req_ready, 1'b1);
    check_b(rsp_valid, 1'b0);
    check_b(bus.q_oe, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    check_b(bus.q_oe, 1'b0);
    $display("reset test done");
    foreach (rows[i])
    begin
      send(rows[i]);
      if (rows[i].rd)
        expect_rd(rows[i]);
    end
    $display("row tests done");
    // two reads back to back, output kept driven across them
    send(rows[4]);
    send(rows[6]);
    expect_rd(rows[4]);
    expect_rd(rows[6]);
    $display("back to back read test done");
    // write then read the same place with no gap
    send('{1'b0, 20'h00001, 18'h3ffff, 18'h00001, 2'h0, 2'h0});
    send('{1'b1, 20'h00001, 18'h3ffff, 18'h00001, 2'h0, 2'h0});
    expect_rd('{1'b1, 20'h00001, 18'h3ffff, 18'h00001, 2'h0, 2'h0});
    $display("write then read test done");
    @(posedge clock_i);
    single_clk <= 1'b1;
    repeat (8) @(posedge clock_i);
    send(rows[4]);
    expect_rd(rows[4]);
    @(posedge clock_i);
    single_clk <= 1'b0;
    $display("single clock test done");
    // contents survive a reset in mid run
    reset_pulse();
    send(rows[1]);
    expect_rd(rows[1]);
    $display("mid run reset test done");
    test_done();
  end
endmodule
